// ### core/priority_pin_crossbar.v
// priority crossbar placing peripheral signals on port pins
//
// Overview of operation
// - enabled smbus port claims two pins, data and clock together.
// - enabled uart claims transmit and receive pins together.
// - uart transmit sits on P0.4 and receive on P0.5 always.
// - unclaimed pins stay ordinary port pins after the placed functions.
// - uart ranks first; later functions take next free unskipped pin.
// - spi claims three pins, or four when slave select is in use.
// - smbus data and clock order follows that port's swap bit.
// - analog pins have pull-up, driver and receiver all off.
// - input mode bit one is digital, zero analog; reset is digital.
// - driver type follows output mode bit even for routed signals, smbus excepted.
// - smbus data and clock pins are always open-drain.
// - pull-up disable clear enables pull-ups on open-drain pins, and on all digital pins while the router is disabled.
// - pull-up is off while the pin drives zero.
// - router disabled keeps all pins plain inputs, ignoring enables.
// - output drivers are off while the router is disabled.
// - register 0xE1 holds per-peripheral route enables, reset zero.
// - bit 7 of 0xE1 enables strong pull-ups on P2.2 and P2.3.
// - each routed signal takes the lowest unassigned pin, uart excepted.
// - skipped pins are passed over as if assigned.
// - register 0xE2 holds pull-up disable, router enable, timer inputs.
// - counter select routes none, channel 0, channels 0-1, channels 0-2.
`timescale 1ns/1ps
`include "crossbar_regs.vh"
module priority_pin_crossbar #(
  parameter NP         = 21,
  parameter ASSIGNABLE = 20
) (
  // clock and reset
  input  wire                  i_sys_clk,
  input  wire                  i_rst_n,
  // special function register port
  input  wire [7:0]            i_sfr_addr,
  input  wire [7:0]            i_sfr_wdata,
  input  wire                  i_sfr_we,
  input  wire                  i_sfr_re,
  output reg  [7:0]            o_sfr_rdata,
  output reg                   o_sfr_hit,
  // per-pin configuration from the port registers
  input  wire [NP-1:0]         i_pin_skip_mask,
  input  wire [NP-1:0]         i_pin_input_mode,
  input  wire [NP-1:0]         i_pin_output_mode,
  input  wire [NP-1:0]         i_port_latch,
  // peripheral configuration
  input  wire [1:0]            i_spi_slave_select_mode,
  input  wire [1:0]            i_smbus_pin_swap,
  // peripheral side
  input  wire [`XB_NF-1:0]     i_func_out,
  input  wire [`XB_NF-1:0]     i_func_drive,
  output reg  [`XB_NF-1:0]     o_func_in,
  // pad side
  input  wire [NP-1:0]         i_pad_in,
  output wire [NP-1:0]         o_pad_out,
  output wire [NP-1:0]         o_pad_oe_n,
  output wire [NP-1:0]         o_pad_pullup,
  output wire [NP-1:0]         o_pad_rx_en,
  output reg  [NP-1:0]         o_port_read,
  output reg  [1:0]            o_strong_pullup,
  output reg  [NP*`XB_FW-1:0]  o_pin_func
);

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0]           crossbar_enables_a;
  reg  [7:0]           crossbar_enables_b;
  reg  [NP-1:0]        skip_q;
  reg  [NP-1:0]        in_mode_q;
  reg  [NP-1:0]        out_mode_q;
  reg  [1:0]           nss_mode_q;
  reg  [1:0]           swap_q;
  reg  [NP*`XB_FW-1:0] next_pin_func;
  reg  [NP-1:0]        occupied;
  reg  [NP-1:0]        drv_value;
  reg  [NP-1:0]        drv_req;
  reg  [NP-1:0]        smbus_pin;
  reg  [`XB_NF-1:0]    next_func_in;
  reg  [`XB_FW-1:0]    slot_f;
  reg  [`XB_FW-1:0]    pf;
  reg                  found;
  integer              s;
  integer              p;
  integer              q;

  wire router_en = crossbar_enables_b[`XB_B_ROUTER_EN_BIT];
  wire wpu_dis   = crossbar_enables_b[`XB_B_WPU_DIS_BIT];

  // ****************************************
  // helper functions
  // ****************************************
  // placement slot to function, honouring smbus swap
  function [`XB_FW-1:0] slot_func;
    input [`XB_FW-1:0] slot;
    input [1:0]        swap;
    begin
      slot_func = slot;
      if (slot == `XB_F_SDA0 && swap[0]) begin
        slot_func = `XB_F_SCL0;
      end else if (slot == `XB_F_SCL0 && swap[0]) begin
        slot_func = `XB_F_SDA0;
      end else if (slot == `XB_F_SDA1 && swap[1]) begin
        slot_func = `XB_F_SCL1;
      end else if (slot == `XB_F_SCL1 && swap[1]) begin
        slot_func = `XB_F_SDA1;
      end
    end
  endfunction

  // whether a function is routed under the current enables
  function func_enabled;
    input [`XB_FW-1:0] f;
    input [7:0]        ea;
    input [7:0]        eb;
    input [1:0]        nss;
    reg   [1:0]        cs;
    begin
      cs = eb[`XB_B_CNT_SEL_LSB +: 2];
      case (f)
        `XB_F_TX, `XB_F_RX:         func_enabled = ea[`XB_A_UART_BIT];
        `XB_F_SCK, `XB_F_MISO,
        `XB_F_MOSI:                 func_enabled = ea[`XB_A_SPI_BIT];
        `XB_F_NSS:                  func_enabled = ea[`XB_A_SPI_BIT] &
                                                   (nss != 2'h0);
        `XB_F_SDA0, `XB_F_SCL0:     func_enabled = ea[`XB_A_SMB0_BIT];
        `XB_F_SDA1, `XB_F_SCL1:     func_enabled = ea[`XB_A_SMB1_BIT];
        `XB_F_CMP:                  func_enabled = ea[`XB_A_CMP_BIT];
        `XB_F_CMP_ASYNC:            func_enabled = ea[`XB_A_CMP_ASYNC_BIT];
        `XB_F_SYSCLK:               func_enabled = ea[`XB_A_SYSCLK_BIT];
        `XB_F_COUNTER_CHANNEL0_OUTPUT:                 func_enabled = (cs != 2'h0);
        `XB_F_CEX1:                 func_enabled = cs[1];
        `XB_F_CEX2:                 func_enabled = (cs == 2'h3);
        `XB_F_ECI:                  func_enabled = eb[`XB_B_ECI_BIT];
        `XB_F_T0:                   func_enabled = eb[`XB_B_T0_BIT];
        `XB_F_T1:                   func_enabled = eb[`XB_B_T1_BIT];
        default:                    func_enabled = 1'b0;
      endcase
    end
  endfunction

  // smbus functions
  function is_smbus;
    input [`XB_FW-1:0] f;
    begin
      is_smbus = (f == `XB_F_SDA0) || (f == `XB_F_SCL0) ||
                 (f == `XB_F_SDA1) || (f == `XB_F_SCL1);
    end
  endfunction

  // ****************************************
  // register port
  // ****************************************
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      crossbar_enables_a <= `XB_ENABLES_A_RESET;
      crossbar_enables_b <= `XB_ENABLES_B_RESET;
    end else if (i_sfr_we) begin
      if (i_sfr_addr == `XB_ENABLES_A_ADDR) begin
        crossbar_enables_a <= i_sfr_wdata;
      end else if (i_sfr_addr == `XB_ENABLES_B_ADDR) begin
        crossbar_enables_b <= i_sfr_wdata & `XB_B_WRITE_MASK;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
      o_sfr_hit   <= 1'b0;
    end else if (i_sfr_re) begin
      if (i_sfr_addr == `XB_ENABLES_A_ADDR) begin
        o_sfr_rdata <= crossbar_enables_a;
        o_sfr_hit   <= 1'b1;
      end else if (i_sfr_addr == `XB_ENABLES_B_ADDR) begin
        o_sfr_rdata <= crossbar_enables_b;
        o_sfr_hit   <= 1'b1;
      end else begin
        o_sfr_rdata <= 8'h00;
        o_sfr_hit   <= 1'b0;
      end
    end else begin
      o_sfr_hit   <= 1'b0;
    end
  end

  // ****************************************
  // configuration capture
  // ****************************************
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      skip_q     <= {NP{`XB_SKIP_RESET}};
      in_mode_q  <= {NP{`XB_IN_MODE_RESET}};
      out_mode_q <= {NP{`XB_OUT_MODE_RESET}};
      nss_mode_q <= 2'h0;
      swap_q     <= 2'h0;
    end else begin
      skip_q     <= i_pin_skip_mask;
      in_mode_q  <= i_pin_input_mode;
      out_mode_q <= i_pin_output_mode;
      nss_mode_q <= i_spi_slave_select_mode;
      swap_q     <= i_smbus_pin_swap;
    end
  end

  // ****************************************
  // priority placement
  // ****************************************
  always @* begin
    next_pin_func = {NP{`XB_F_NONE}};
    occupied      = skip_q;
    found         = 1'b0;
    slot_f        = `XB_F_NONE;
    for (p = ASSIGNABLE; p < NP; p = p + 1) begin
      occupied[p] = 1'b1;
    end
    if (router_en) begin
      if (crossbar_enables_a[`XB_A_UART_BIT]) begin
        next_pin_func[`XB_UART_TX_PIN*`XB_FW +: `XB_FW] = `XB_F_TX;
        next_pin_func[`XB_UART_RX_PIN*`XB_FW +: `XB_FW] = `XB_F_RX;
        occupied[`XB_UART_TX_PIN] = 1'b1;
        occupied[`XB_UART_RX_PIN] = 1'b1;
      end
      for (s = `XB_F_SCK; s < `XB_NF; s = s + 1) begin
        slot_f = slot_func(s[`XB_FW-1:0], swap_q);
        if (func_enabled(slot_f, crossbar_enables_a, crossbar_enables_b, nss_mode_q)) begin
          found = 1'b0;
          for (p = 0; p < NP; p = p + 1) begin
            if (!found && !occupied[p]) begin
              found       = 1'b1;
              occupied[p] = 1'b1;
              next_pin_func[p*`XB_FW +: `XB_FW] = slot_f;
            end
          end
        end
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_pin_func <= {NP{`XB_F_NONE}};
    end else begin
      o_pin_func <= next_pin_func;
    end
  end

  // ****************************************
  // per-pin drive selection
  // ****************************************
  always @* begin
    drv_value    = i_port_latch;
    drv_req      = {NP{1'b1}};
    smbus_pin    = {NP{1'b0}};
    next_func_in = {`XB_NF{1'b1}};
    pf           = `XB_F_NONE;
    for (q = 0; q < NP; q = q + 1) begin
      pf = o_pin_func[q*`XB_FW +: `XB_FW];
      if (pf != `XB_F_NONE) begin
        drv_value[q] = i_func_out[pf];
        drv_req[q]   = i_func_drive[pf];
        smbus_pin[q] = is_smbus(pf);
        next_func_in[pf] = i_pad_in[q] & in_mode_q[q];
      end
    end
  end

  // ****************************************
  // pad controls
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : pads
      pad_cell_ctrl u_pad (
        .i_sys_clk             (i_sys_clk),
        .i_rst_n               (i_rst_n),
        .i_router_en           (router_en),
        .i_digital             (in_mode_q[g]),
        .i_push_pull           (out_mode_q[g]),
        .i_force_od            (smbus_pin[g]),
        .i_weak_pullup_disable (wpu_dis),
        .i_value               (drv_value[g]),
        .i_drive               (drv_req[g]),
        .o_pad_out             (o_pad_out[g]),
        .o_pad_oe_n            (o_pad_oe_n[g]),
        .o_pad_pullup          (o_pad_pullup[g]),
        .o_pad_rx_en           (o_pad_rx_en[g])
      );
    end
  endgenerate

  // ****************************************
  // read back and peripheral inputs
  // ****************************************
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_port_read     <= {NP{1'b0}};
      o_func_in       <= {`XB_NF{1'b1}};
      o_strong_pullup <= 2'h0;
    end else begin
      o_port_read     <= i_pad_in & in_mode_q;
      o_func_in       <= next_func_in;
      o_strong_pullup <= {2{crossbar_enables_a[`XB_A_EE_PULLUP_BIT]}};
    end
  end

endmodule // priority_pin_crossbar

// ### core/crossbar_regs.vh
// register offsets, field positions, reset values and codes of the pin crossbar
`ifndef CROSSBAR_REGS_VH
`define CROSSBAR_REGS_VH

// ****************************************
// register addresses
// ****************************************
`define XB_ENABLES_A_ADDR    8'hE1
`define XB_ENABLES_B_ADDR    8'hE2

// ****************************************
// reset values
// ****************************************
`define XB_ENABLES_A_RESET   8'h00
`define XB_ENABLES_B_RESET   8'h00
`define XB_IN_MODE_RESET     1'h1
`define XB_OUT_MODE_RESET    1'h0
`define XB_SKIP_RESET        1'h0

// ****************************************
// crossbar_enables_a fields
// ****************************************
`define XB_A_UART_BIT        0
`define XB_A_SPI_BIT         1
`define XB_A_SMB0_BIT        2
`define XB_A_SYSCLK_BIT      3
`define XB_A_CMP_BIT         4
`define XB_A_CMP_ASYNC_BIT   5
`define XB_A_SMB1_BIT        6
`define XB_A_EE_PULLUP_BIT   7

// ****************************************
// crossbar_enables_b fields
// ****************************************
`define XB_B_CNT_SEL_LSB     0
`define XB_B_UNUSED_BIT      2
`define XB_B_ECI_BIT         3
`define XB_B_T0_BIT          4
`define XB_B_T1_BIT          5
`define XB_B_ROUTER_EN_BIT   6
`define XB_B_WPU_DIS_BIT     7
`define XB_B_WRITE_MASK      8'hFB

// ****************************************
// fixed pins
// ****************************************
`define XB_UART_TX_PIN       4
`define XB_UART_RX_PIN       5
`define XB_EE_PIN0           18
`define XB_EE_PIN1           19

// ****************************************
// function codes, in priority order
// ****************************************
`define XB_FW                5
`define XB_NF                19
`define XB_F_TX              5'h00
`define XB_F_RX              5'h01
`define XB_F_SCK             5'h02
`define XB_F_MISO            5'h03
`define XB_F_MOSI            5'h04
`define XB_F_NSS             5'h05
`define XB_F_SDA0            5'h06
`define XB_F_SCL0            5'h07
`define XB_F_SDA1            5'h08
`define XB_F_SCL1            5'h09
`define XB_F_CMP             5'h0A
`define XB_F_CMP_ASYNC       5'h0B
`define XB_F_SYSCLK          5'h0C
`define XB_F_COUNTER_CHANNEL0_OUTPUT            5'h0D
`define XB_F_CEX1            5'h0E
`define XB_F_CEX2            5'h0F
`define XB_F_ECI             5'h10
`define XB_F_T0              5'h11
`define XB_F_T1              5'h12
`define XB_F_NONE            5'h1F

`endif

// ### core/pad_cell_ctrl.v
// one pad's driver, pull-up and receiver control
`timescale 1ns/1ps
module pad_cell_ctrl (
  // clock and reset
  input  wire i_sys_clk,
  input  wire i_rst_n,
  // configuration
  input  wire i_router_en,
  input  wire i_digital,
  input  wire i_push_pull,
  input  wire i_force_od,
  input  wire i_weak_pullup_disable,
  // drive request
  input  wire i_value,
  input  wire i_drive,
  // pad controls
  output reg  o_pad_out,
  output reg  o_pad_oe_n,
  output reg  o_pad_pullup,
  output reg  o_pad_rx_en
);

  reg next_oe;
  reg next_out;
  reg od;

  // ****************************************
  // drive decision
  // ****************************************
  always @* begin
    od       = ~i_push_pull | i_force_od;
    next_out = i_value;
    next_oe  = i_router_en & i_digital & i_drive;
    if (od && i_value) begin
      next_oe = 1'b0;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_pad_out    <= 1'b1;
      o_pad_oe_n   <= 1'b1;
      o_pad_pullup <= 1'b0;
      o_pad_rx_en  <= 1'b1;
    end else begin
      o_pad_out    <= next_out;
      o_pad_oe_n   <= ~next_oe;
      // pull-up on digital pins not pulling low that are open-drain or have the router disabled
      o_pad_pullup <= i_digital & ~i_weak_pullup_disable & (od | ~i_router_en)
                      & ~(next_oe & ~next_out);
      o_pad_rx_en  <= i_digital;
    end
  end

endmodule // pad_cell_ctrl

// ### verif/priority_pin_crossbar_chk.sv
// concurrent checks on the pin crossbar ports
`timescale 1ns/1ps
`include "crossbar_regs.vh"
module priority_pin_crossbar_chk #(
  parameter NP = 21
) (
  // clock and reset
  input logic                 i_sys_clk,
  input logic                 i_rst_n,
  // register port
  input logic [7:0]           i_sfr_addr,
  input logic [7:0]           i_sfr_wdata,
  input logic                 i_sfr_we,
  input logic                 i_sfr_re,
  input logic [7:0]           o_sfr_rdata,
  input logic                 o_sfr_hit,
  // pins
  input logic [NP-1:0]        i_pin_input_mode,
  input logic [NP-1:0]        o_pad_out,
  input logic [NP-1:0]        o_pad_oe_n,
  input logic [NP-1:0]        o_pad_pullup,
  input logic [NP-1:0]        o_pad_rx_en,
  input logic [1:0]           o_strong_pullup,
  input logic [NP*`XB_FW-1:0] o_pin_func
);
  localparam int FW = `XB_FW;
  logic [7:0]    ea;
  logic [7:0]    eb;
  logic [1:0]    up;
  logic [FW-1:0] f;
  logic [NP-1:0] smb;
  logic [NP-1:0] none;
  int            s0d, s0c, s1d, s1c, bad_u;
  // ****
  // register shadows and pin census
  // ****
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ea <= 8'h00;
      eb <= 8'h00;
      up <= 2'h0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (i_sfr_we && i_sfr_addr == `XB_ENABLES_A_ADDR) ea <= i_sfr_wdata;
      if (i_sfr_we && i_sfr_addr == `XB_ENABLES_B_ADDR) eb <= i_sfr_wdata & 8'hFB;
    end
  end
  always_comb begin
    s0d = 0; s0c = 0; s1d = 0; s1c = 0; bad_u = 0;
    for (int k = 0; k < NP; k++) begin
      f = o_pin_func[k*FW +: FW];
      smb[k] = f >= `XB_F_SDA0 && f <= `XB_F_SCL1;
      none[k] = f == `XB_F_NONE;
      s0d += int'(f == `XB_F_SDA0);
      s0c += int'(f == `XB_F_SCL0);
      s1d += int'(f == `XB_F_SDA1);
      s1c += int'(f == `XB_F_SCL1);
      bad_u += int'(f == `XB_F_TX && k != 4) + int'(f == `XB_F_RX && k != 5);
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence rd_a; i_sfr_re && !i_sfr_we && i_sfr_addr == `XB_ENABLES_A_ADDR; endsequence
  sequence rd_b; i_sfr_re && !i_sfr_we && i_sfr_addr == `XB_ENABLES_B_ADDR; endsequence
  sequence rd_x; i_sfr_re && i_sfr_addr != 8'hE1 && i_sfr_addr != 8'hE2; endsequence
  a_uart_fixed_pair: assert property (
    bad_u == 0 && (o_pin_func[20 +: FW] == `XB_F_TX) == (o_pin_func[25 +: FW] == `XB_F_RX))
    else $error("uart pins misplaced");
  a_smbus_two_pins: assert property (s0d == s0c && s1d == s1c)
    else $error("smbus pin pair broken");
  a_analog_all_off: assert property (up == 2'h3 |->
    ((~($past(i_pin_input_mode) | $past(i_pin_input_mode, 2) | $past(i_pin_input_mode, 3)))
     & (~o_pad_oe_n | o_pad_pullup | o_pad_rx_en)) == '0)
    else $error("analog pin not fully off");
  a_router_off_funcs: assert property (!(eb[6] | $past(eb[6])) |-> &none)
    else $error("function placed while router off");
  a_router_off_drive: assert property (
    !(eb[6] | $past(eb[6]) | $past(eb[6], 2)) |-> &o_pad_oe_n)
    else $error("pad driven while router off");
  a_strong_pullup_bit: assert property ($stable(ea[7]) |-> o_strong_pullup == {2{ea[7]}})
    else $error("strong pull-up mismatch");
  a_read_enables_a: assert property (rd_a |=> o_sfr_hit && o_sfr_rdata == $past(ea))
    else $error("enables_a read mismatch");
  a_read_enables_b: assert property (rd_b |=> o_sfr_hit && o_sfr_rdata == $past(eb))
    else $error("enables_b read mismatch");
  a_unmapped_read_zero: assert property (rd_x |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  a_pullup_low_off: assert property ((~o_pad_oe_n & ~o_pad_out & o_pad_pullup) == '0)
    else $error("pull-up on while driving low");
  a_smbus_open_drain: assert property (($past(smb) & smb & ~o_pad_oe_n & o_pad_out) == '0)
    else $error("smbus pin driven high");
endmodule // priority_pin_crossbar_chk
bind priority_pin_crossbar priority_pin_crossbar_chk #(.NP(NP)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wdata(i_sfr_wdata), .i_sfr_we(i_sfr_we), .i_sfr_re(i_sfr_re),
  .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_pin_input_mode(i_pin_input_mode),
  .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n), .o_pad_pullup(o_pad_pullup),
  .o_pad_rx_en(o_pad_rx_en), .o_strong_pullup(o_strong_pullup), .o_pin_func(o_pin_func)
);

// ### verif/pad_line_model.sv
// pad-side model resolving each pad line from all drivers
`timescale 1ns/1ps
module pad_line_model #(
  parameter NP = 21
) (
  // clock
  input  logic          i_sys_clk,
  // device pad controls
  input  logic [NP-1:0] i_pad_out,
  input  logic [NP-1:0] i_pad_oe_n,
  input  logic [NP-1:0] i_pad_pullup,
  // external driver
  input  logic [NP-1:0] i_ext_en,
  input  logic [NP-1:0] i_ext_val,
  // resolved level
  output logic [NP-1:0] o_pad_level
);
  logic drift = 1'b0;
  // an undriven, unpulled line wanders every cycle
  always @(posedge i_sys_clk) drift <= ~drift;
  always_comb begin
    for (int k = 0; k < NP; k++) begin
      if (!i_pad_oe_n[k]) o_pad_level[k] = i_pad_out[k];
      else if (i_ext_en[k]) o_pad_level[k] = i_ext_val[k];
      else o_pad_level[k] = i_pad_pullup[k] | drift;
    end
  end
endmodule // pad_line_model

// ### verif/test_priority_pin_crossbar.sv
// self-checking bench for the priority pin crossbar
`timescale 1ns/1ps
module test_priority_pin_crossbar;
  typedef struct {logic [7:0] a, b, sk; logic [1:0] sw, ns; logic [63:0] ex;} row_t;
  logic         clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, hit;
  logic [7:0]   ad = 8'h00, wd = 8'h00, rd;
  logic [20:0]  sk = '0, inm = '1, outm = '0, lat = '0, xen = '0, xv = '0;
  logic [20:0]  pin, pout, oen, pu, rxe, prd;
  logic [1:0]   nss = 2'h0, swp = 2'h0, spu;
  logic [18:0]  fo = 19'h00041, fd = 19'h000C1, fi;
  logic [104:0] pf;
  int           err_count = 0, checks = 0;
  // pin k code at byte k of ex
  row_t rows [7] = '{
    '{8'h05, 8'h41, 8'h0C, 2'h0, 2'h0, 64'h1F0D01001F1F0706},
    '{8'h03, 8'h42, 8'h00, 2'h0, 2'h1, 64'h0E0D010005040302},
    '{8'h02, 8'h40, 8'h00, 2'h0, 2'h0, 64'h1F1F1F1F1F040302},
    '{8'h44, 8'h40, 8'h01, 2'h1, 2'h0, 64'h1F1F1F090806071F},
    '{8'h38, 8'h43, 8'h02, 2'h0, 2'h0, 64'h1F0F0E0D0C0B1F0A},
    '{8'h01, 8'h78, 8'h01, 2'h0, 2'h0, 64'h1F1F01001211101F},
    '{8'hFF, 8'h3F, 8'h00, 2'h0, 2'h0, 64'h1F1F1F1F1F1F1F1F}
  };
  priority_pin_crossbar DUT (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(ad), .i_sfr_wdata(wd),
    .i_sfr_we(we), .i_sfr_re(re), .o_sfr_rdata(rd), .o_sfr_hit(hit),
    .i_pin_skip_mask(sk), .i_pin_input_mode(inm), .i_pin_output_mode(outm),
    .i_port_latch(lat), .i_spi_slave_select_mode(nss), .i_smbus_pin_swap(swp),
    .i_func_out(fo), .i_func_drive(fd), .o_func_in(fi), .i_pad_in(pin),
    .o_pad_out(pout), .o_pad_oe_n(oen), .o_pad_pullup(pu), .o_pad_rx_en(rxe),
    .o_port_read(prd), .o_strong_pullup(spu), .o_pin_func(pf)
  );
  pad_line_model #(.NP(21)) u_pads (
    .i_sys_clk(clk), .i_pad_out(pout), .i_pad_oe_n(oen), .i_pad_pullup(pu),
    .i_ext_en(xen), .i_ext_val(xv), .o_pad_level(pin)
  );
  // ****
  // tasks
  // ****
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ad = a; wd = d; we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [8:0] exp);
    @(negedge clk);
    ad = a; re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    cmp({hit, rd}, exp);
  endtask
  task automatic complete_run();
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // clock, watchdog, sequence
  // ****
  always #4 clk = ~clk;
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    rdc(8'hE1, 9'h100);
    rdc(8'hE2, 9'h100);
    rdc(8'hE3, 9'h000);
    cmp(oen, 21'h1FFFFF);
    cmp(rxe, 21'h1FFFFF);
    cmp(pu, 21'h1FFFFF);
    cmp(spu, 2'h0);
    foreach (rows[i]) begin
      sk = {13'h0000, rows[i].sk}; swp = rows[i].sw; nss = rows[i].ns;
      wr(8'hE1, rows[i].a);
      wr(8'hE2, rows[i].b);
      repeat (2) @(negedge clk);
      for (int k = 0; k < 8; k++) cmp(pf[5*k +: 5], rows[i].ex[8*k +: 5]);
      cmp(spu, {2{rows[i].a[7]}});
    end
    // gpio output blocked while router off
    outm = '1;
    repeat (3) @(negedge clk);
    cmp(oen, 21'h1FFFFF);
    // analog pin, gpio drive kinds, uart push-pull, new routing one cycle late
    outm = 21'h000110; lat = 21'h000300; inm = 21'h1FFF7F; sk = 21'h000080;
    wr(8'hE1, 8'h01);
    wr(8'hE2, 8'h40);
    cmp(pf[24:20], 5'h1F);
    @(negedge clk);
    cmp(pf[29:20], 10'h020);
    repeat (3) @(negedge clk);
    cmp({oen[10:8], pout[10], pout[8]}, 5'b01001);
    cmp(pu[10:9], 2'b01);
    cmp(prd[9], 1'b1);
    cmp({oen[7], pu[7], rxe[7], prd[7]}, 4'b1000);
    cmp({oen[4], pout[4]}, 2'b01);
    wr(8'hE2, 8'hC0);
    repeat (2) @(negedge clk);
    cmp(pu[9], 1'b0);
    // smbus on push-pull pins stays open-drain, receive pin fed from pad
    outm = 21'h000113; xen = 21'h000020;
    wr(8'hE1, 8'h05);
    rdc(8'hE1, 9'h105);
    repeat (3) @(negedge clk);
    cmp(oen[1:0], 2'b01);
    cmp(fi[1], 1'b0);
    wr(8'hE2, 8'hFF);
    rdc(8'hE2, 9'h1FB);
    // second reset in mid-run
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rdc(8'hE1, 9'h100);
    cmp(oen, 21'h1FFFFF);
    complete_run();
  end
endmodule // test_priority_pin_crossbar
